// file: logic/dcsw_pkg.sv
// Package for the drive control/status word block.
// Holds bit positions, setting codes and timing constants; no logic.
package dcsw_pkg;
    // Control word bit positions
    localparam int CW_REF_LO = 0;
    localparam int CW_COAST = 3;
    localparam int CW_QSTOP = 4;
    localparam int CW_FREEZE = 5;
    localparam int CW_START = 6;
    localparam int CW_RESET = 7;
    localparam int CW_JOG1 = 8;
    localparam int CW_RAMP = 9;
    localparam int CW_VALID = 10;
    localparam int CW_RELAY = 11;
    localparam int CW_DOUT = 12;
    localparam int CW_SETUP_LO = 13;
    localparam int CW_REV = 15;

    // Reset value of the latched command word (data valid clear)
    localparam logic [15:0] CW_RESET_VAL = 16'h0000;

    // Active-setup setting codes
    typedef enum logic [1:0] {
        DCSW_SETUP_FIXED = 2'b00,
        DCSW_SETUP_MULTI = 2'b01
    } dcsw_setup_mode_t;

    // Reversing source setting codes
    typedef enum logic [1:0] {
        DCSW_REV_DIGITAL = 2'b00,
        DCSW_REV_SERIAL = 2'b01,
        DCSW_REV_OR = 2'b10,
        DCSW_REV_AND = 2'b11
    } dcsw_rev_src_t;

    // Message profile setting: 0 selects the alternative bus layout
    localparam logic MSG_PROFILE_BUS = 1'b0;

    // Input monitor refresh
    localparam int CLK_HZ = 125_000_000;
    localparam int INPUT_PERIOD_MS = 10;
    localparam int INPUT_PERIOD_CYC = CLK_HZ / 1000 * INPUT_PERIOD_MS;
endpackage

// file: logic/dcsw_input_sampler.sv
// Periodic sampler for the five monitored digital inputs.
// Assumes inputs are already synchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module dcsw_input_sampler #(
    parameter int PERIOD_CYC = dcsw_pkg::INPUT_PERIOD_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Raw inputs and sampled copy
    input wire logic [4:0] din_in,
    output logic [4:0] din_out
);
    typedef struct packed {
        logic [31:0] cnt;
        logic [4:0] held;
    } dcsw_smp_state_t;

    dcsw_smp_state_t s_reg;
    dcsw_smp_state_t s_next;

    // Sampling every cycle would be fine too; the refresh bounds latency
    always_comb begin
        s_next = s_reg;
        if (s_reg.cnt >= 32'(PERIOD_CYC - 1)) begin
            s_next.cnt = '0;
            s_next.held = din_in;
        end else begin
            s_next.cnt = s_reg.cnt + 32'd1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign din_out = s_reg.held;

    a_input_latency: assert property (@(posedge clk_in) disable iff (rst_in)
        (s_reg.cnt == 32'(PERIOD_CYC - 1)) |=> (din_out == $past(din_in)))
        else $error("sampled input not taken at period end");
endmodule
`default_nettype wire

// file: logic/dcsw_core.sv
// Drive control word decoder and status word assembler.
// Assumes the link layer presents each received control word with a
// one-cycle strobe, and drive state as plain synchronous levels.
`timescale 1ns/1ps
`default_nettype none
module dcsw_core #(
    parameter int INPUT_PERIOD_CYC = dcsw_pkg::INPUT_PERIOD_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Received control word
    input wire logic [15:0] cmd_word_in,
    input wire logic cmd_strobe_in,
    // Configuration
    input wire logic msg_profile_in,
    input wire logic direct_input_profile_in,
    input wire logic [1:0] setup_mode_in,
    input wire logic [1:0] rev_src_in,
    input wire logic rev_digital_in,
    input wire logic local_stop_in,
    input wire logic local_op_in,
    // Drive state
    input wire logic drive_ready_in,
    input wire logic coast_di_in,
    input wire logic fault_in,
    input wire logic lock_fault_in,
    input wire logic power_removed_in,
    input wire logic warning_in,
    input wire logic speed_at_ref_in,
    input wire logic freq_at_limit_in,
    input wire logic freq_nonzero_in,
    input wire logic start_di_in,
    input wire logic dc_volt_bad_in,
    input wire logic over_current_in,
    input wire logic over_temp_in,
    // Monitored inputs: 27, 18, 19, 29, 33
    input wire logic [4:0] din_in,
    // Decoded commands
    output logic ramp2_sel_out,
    output logic relay_out,
    output logic dig_out,
    output logic [1:0] setup_sel_out,
    output logic reverse_out,
    output logic start_out,
    output logic coast_n_out,
    output logic quick_stop_n_out,
    output logic freeze_n_out,
    output logic [2:0] off_n_out,
    output logic jog1_out,
    output logic jog2_out,
    output logic [1:0] preset_ref_out,
    output logic slow_down_out,
    output logic catch_up_out,
    output logic trip_reset_out,
    // Returned status word
    output logic [15:0] status_word_out
);
    typedef struct packed {
        logic [15:0] cw;
        logic cw_reset_prev;
        logic tripped;
        logic locked;
        logic reset_pulse;
        logic [15:0] status;
    } dcsw_core_state_t;

    dcsw_core_state_t s_reg;
    dcsw_core_state_t s_next;
    typedef dcsw_pkg::dcsw_rev_src_t dcsw_rev_t;
    logic [4:0] din_held;
    logic serial_ok;
    logic bus_layout;
    logic accept;
    logic coast_active;
    logic reset_edge;
    logic [15:0] cw_in_next;
    logic [15:0] native_word;

    // ----------------------------------------------------------------
    // Input monitor
    // ----------------------------------------------------------------
    dcsw_input_sampler #(
        .PERIOD_CYC(INPUT_PERIOD_CYC)
    ) u_sampler (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .din_in(din_in),
        .din_out(din_held)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        serial_ok = !(local_stop_in || local_op_in);
        bus_layout = (msg_profile_in == dcsw_pkg::MSG_PROFILE_BUS);
        // Words with data valid clear, or refused locally, change nothing
        accept = cmd_strobe_in && cmd_word_in[dcsw_pkg::CW_VALID] && serial_ok;
        cw_in_next = accept ? cmd_word_in : s_reg.cw;
        s_next.cw = cw_in_next;
        s_next.cw_reset_prev = cw_in_next[dcsw_pkg::CW_RESET];
        reset_edge = cw_in_next[dcsw_pkg::CW_RESET] && !s_reg.cw_reset_prev;
        s_next.reset_pulse = reset_edge;

        // Trip: set wins over reset
        if (fault_in) begin
            s_next.tripped = 1'b1;
        end else if (reset_edge && !s_reg.locked) begin
            s_next.tripped = 1'b0;
        end
        // Lock clears only after power removal, never by a reset
        if (lock_fault_in) begin
            s_next.locked = 1'b1;
        end else if (power_removed_in) begin
            s_next.locked = 1'b0;
        end

        coast_active = !cw_in_next[dcsw_pkg::CW_COAST] || coast_di_in;
        native_word = '0;
        native_word[0] = drive_ready_in && !s_reg.tripped;
        native_word[1] = drive_ready_in && coast_active;
        native_word[2] = !coast_active;
        native_word[3] = s_reg.tripped;
        native_word[6] = s_reg.locked;
        native_word[7] = warning_in;
        native_word[8] = speed_at_ref_in;
        native_word[9] = serial_ok;
        native_word[10] = !freq_at_limit_in;
        native_word[11] = start_di_in || cw_in_next[dcsw_pkg::CW_START]
            || freq_nonzero_in;
        native_word[13] = dc_volt_bad_in;
        native_word[14] = over_current_in;
        native_word[15] = over_temp_in;
        if (direct_input_profile_in) begin
            native_word[5] = din_held[0];
            native_word[12] = din_held[1];
            native_word[13] = din_held[2];
            native_word[14] = din_held[3];
            native_word[15] = din_held[4];
        end
        s_next.status = native_word;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_reg <= '{cw: dcsw_pkg::CW_RESET_VAL, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // Registered command outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ramp2_sel_out <= 1'b0;
            relay_out <= 1'b0;
            dig_out <= 1'b0;
            setup_sel_out <= 2'b00;
            reverse_out <= 1'b0;
            start_out <= 1'b0;
            coast_n_out <= 1'b0;
            quick_stop_n_out <= 1'b0;
            freeze_n_out <= 1'b0;
            off_n_out <= 3'b000;
            jog1_out <= 1'b0;
            jog2_out <= 1'b0;
            preset_ref_out <= 2'b00;
            slow_down_out <= 1'b0;
            catch_up_out <= 1'b0;
            trip_reset_out <= 1'b0;
            status_word_out <= 16'h0000;
        end else begin
            coast_n_out <= s_reg.cw[dcsw_pkg::CW_COAST];
            quick_stop_n_out <= s_reg.cw[dcsw_pkg::CW_QSTOP];
            freeze_n_out <= s_reg.cw[dcsw_pkg::CW_FREEZE];
            start_out <= s_reg.cw[dcsw_pkg::CW_START];
            trip_reset_out <= s_reg.reset_pulse;
            if (setup_mode_in == dcsw_pkg::DCSW_SETUP_MULTI) begin
                setup_sel_out <= s_reg.cw[dcsw_pkg::CW_SETUP_LO +: 2];
            end
            unique case (dcsw_rev_t'(rev_src_in))
                dcsw_pkg::DCSW_REV_DIGITAL: reverse_out <= rev_digital_in;
                dcsw_pkg::DCSW_REV_SERIAL: reverse_out <= s_reg.cw[dcsw_pkg::CW_REV];
                dcsw_pkg::DCSW_REV_OR: reverse_out <= s_reg.cw[dcsw_pkg::CW_REV]
                    || rev_digital_in;
                dcsw_pkg::DCSW_REV_AND: reverse_out <= s_reg.cw[dcsw_pkg::CW_REV]
                    && rev_digital_in;
            endcase
            if (bus_layout) begin
                // Alternative layout; slow-down wins over catch-up
                off_n_out <= s_reg.cw[2:0];
                jog1_out <= s_reg.cw[dcsw_pkg::CW_JOG1];
                jog2_out <= s_reg.cw[dcsw_pkg::CW_RAMP];
                slow_down_out <= s_reg.cw[dcsw_pkg::CW_RELAY];
                catch_up_out <= s_reg.cw[dcsw_pkg::CW_DOUT] && !s_reg.cw[dcsw_pkg::CW_RELAY];
                preset_ref_out <= 2'b00;
                ramp2_sel_out <= 1'b0;
                relay_out <= 1'b0;
                dig_out <= 1'b0;
            end else begin
                off_n_out <= 3'b111;
                jog1_out <= s_reg.cw[dcsw_pkg::CW_JOG1];
                jog2_out <= 1'b0;
                slow_down_out <= 1'b0;
                catch_up_out <= 1'b0;
                preset_ref_out <= s_reg.cw[dcsw_pkg::CW_REF_LO +: 2];
                ramp2_sel_out <= s_reg.cw[dcsw_pkg::CW_RAMP];
                relay_out <= s_reg.cw[dcsw_pkg::CW_RELAY];
                dig_out <= s_reg.cw[dcsw_pkg::CW_DOUT];
            end
            status_word_out <= s_reg.status;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_invalid_word;
        cmd_strobe_in && !cmd_word_in[dcsw_pkg::CW_VALID];
    endsequence

    a_invalid_ignored: assert property (@(posedge clk_in) disable iff (rst_in)
        s_invalid_word |=> $stable(s_reg.cw))
        else $error("word with data valid clear was taken");
    a_ramp_follow: assert property (@(posedge clk_in) disable iff (rst_in)
        !bus_layout |=> (ramp2_sel_out == $past(s_reg.cw[dcsw_pkg::CW_RAMP])))
        else $error("ramp select does not follow word");
    a_relay_follow: assert property (@(posedge clk_in) disable iff (rst_in)
        !bus_layout |=> (relay_out == $past(s_reg.cw[dcsw_pkg::CW_RELAY])))
        else $error("relay does not follow word");
    a_setup_held: assert property (@(posedge clk_in) disable iff (rst_in)
        (setup_mode_in != dcsw_pkg::DCSW_SETUP_MULTI) |=> $stable(setup_sel_out))
        else $error("setup changed outside multi-setup");
    a_rev_digital: assert property (@(posedge clk_in) disable iff (rst_in)
        (rev_src_in == dcsw_pkg::DCSW_REV_DIGITAL) |=> (reverse_out == $past(rev_digital_in)))
        else $error("serial reversing in digital mode");
    a_reset_edge: assert property (@(posedge clk_in) disable iff (rst_in)
        (s_reg.cw_reset_prev && s_reg.cw[dcsw_pkg::CW_RESET]) |=> !s_reg.reset_pulse)
        else $error("reset pulse while bit merely held");
    a_lock_holds: assert property (@(posedge clk_in) disable iff (rst_in)
        (s_reg.locked && !power_removed_in) |=> s_reg.locked)
        else $error("trip lock cleared without power removal");
    a_unused_zero: assert property (@(posedge clk_in) disable iff (rst_in)
        !direct_input_profile_in ##1 !$past(direct_input_profile_in)
        |-> (s_reg.status[5:4] == 2'b00) && !s_reg.status[12])
        else $error("unused status bit set");
    a_trip_status: assert property (@(posedge clk_in) disable iff (rst_in)
        s_reg.tripped |=> ##1 status_word_out[3] || !s_reg.tripped)
        else $error("trip not shown in status");

    // Reset acts in two steps: internal pulse, then the registered output
    sequence s_reset_rise;
        accept && cmd_word_in[dcsw_pkg::CW_RESET] && !s_reg.cw[dcsw_pkg::CW_RESET];
    endsequence
    sequence s_reset_out;
        s_reg.reset_pulse ##1 trip_reset_out;
    endsequence

    a_reset_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
        s_reset_rise |=> s_reset_out)
        else $error("rising reset bit gave no reset pulse");
    a_coast_status: assert property (@(posedge clk_in) disable iff (rst_in)
        coast_di_in |=> !s_reg.status[2])
        else $error("startable shown while coasting");
    a_ready_status: assert property (@(posedge clk_in) disable iff (rst_in)
        !drive_ready_in |=> (!s_reg.status[0] && !s_reg.status[1]))
        else $error("ready shown while drive not ready");
    a_trip_set: assert property (@(posedge clk_in) disable iff (rst_in)
        fault_in |=> s_reg.tripped)
        else $error("fault did not set trip");
    a_local_refused: assert property (@(posedge clk_in) disable iff (rst_in)
        (cmd_strobe_in && !serial_ok) |=> $stable(s_reg.cw))
        else $error("word taken under local control");
    a_bus_offs: assert property (@(posedge clk_in) disable iff (rst_in)
        bus_layout |=> (off_n_out == $past(s_reg.cw[2:0])))
        else $error("off commands do not follow word");
    a_input_map: assert property (@(posedge clk_in) disable iff (rst_in)
        direct_input_profile_in |=> (s_reg.status[5] == $past(din_held[0]))
        && (s_reg.status[15:12] == $past(din_held[4:1])))
        else $error("monitored inputs not mapped to status");
endmodule
`default_nettype wire

// file: sim/dcsw_master_model.sv
// Serial master model: hands control words to the block with a strobe.
// Assumes the caller enters send_word just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module dcsw_master_model (
    // Clock
    input wire logic clk_in,
    // Control word link
    output logic [15:0] cmd_word_out,
    output logic cmd_strobe_out
);
    initial begin
        cmd_word_out = 16'h0000;
        cmd_strobe_out = 1'b0;
    end

    // Released word shows the inverse so a stale word that had data valid set no longer looks valid
    task automatic send_word(input logic [15:0] w);
        @(posedge clk_in);
        #1;
        cmd_word_out = w;
        cmd_strobe_out = 1'b1;
        @(posedge clk_in);
        #1;
        cmd_strobe_out = 1'b0;
        cmd_word_out = ~w;
    endtask
endmodule
`default_nettype wire

// file: sim/drive_control_status_words_tb.sv
// Self-checking bench for the control word decoder and status assembler.
// Assumes dcsw_core and the master model; monitor period shortened to 4.
`timescale 1ns/1ps
`default_nettype none
module drive_control_status_words_tb;
    localparam int PER = 4;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic msg_profile = 1'b1;
    logic dip = 1'b0;
    logic [1:0] setup_mode = 2'b00;
    logic [1:0] rev_src = 2'b00;
    logic rev_dig = 1'b0;
    logic fault = 1'b0;
    logic lock = 1'b0;
    logic pwr_off = 1'b0;
    logic [11:0] st = 12'h000;
    logic [4:0] din = 5'h00;
    wire logic [15:0] cmd_word;
    wire logic cmd_strobe;
    logic ramp2, relay, dout, rev, tr_pulse, jog1, jog2, slow, catch_up;
    logic run, coast_n, qstop_n, freeze_n;
    logic [1:0] setup_sel, preset;
    logic [2:0] off_n;
    logic [15:0] sw;
    int err_total = 0;
    int checked = 0;
    int pulses = 0;
    int cyc = 0;
    logic [15:0] wt [6] = '{16'h1E08, 16'h0008, 16'h0408, 16'h0608, 16'h0C08, 16'h1408};
    logic [2:0] et [6] = '{3'b111, 3'b111, 3'b000, 3'b100, 3'b010, 3'b001};

    always #4 clk_in = ~clk_in;

    dcsw_master_model mst_u (.clk_in(clk_in), .cmd_word_out(cmd_word), .cmd_strobe_out(cmd_strobe));

    dcsw_core #(.INPUT_PERIOD_CYC(PER)) dut_u (
        .clk_in(clk_in), .rst_in(rst_in), .cmd_word_in(cmd_word), .cmd_strobe_in(cmd_strobe),
        .msg_profile_in(msg_profile), .direct_input_profile_in(dip),
        .setup_mode_in(setup_mode), .rev_src_in(rev_src), .rev_digital_in(rev_dig),
        .local_stop_in(st[10]), .local_op_in(st[11]), .drive_ready_in(st[0]),
        .coast_di_in(st[1]), .fault_in(fault), .lock_fault_in(lock),
        .power_removed_in(pwr_off), .warning_in(st[2]), .speed_at_ref_in(st[3]),
        .freq_at_limit_in(st[4]), .freq_nonzero_in(st[5]), .start_di_in(st[6]),
        .dc_volt_bad_in(st[7]), .over_current_in(st[8]), .over_temp_in(st[9]), .din_in(din),
        .ramp2_sel_out(ramp2), .relay_out(relay), .dig_out(dout), .setup_sel_out(setup_sel),
        .reverse_out(rev), .start_out(run), .coast_n_out(coast_n), .quick_stop_n_out(qstop_n),
        .freeze_n_out(freeze_n), .off_n_out(off_n), .jog1_out(jog1), .jog2_out(jog2),
        .preset_ref_out(preset), .slow_down_out(slow), .catch_up_out(catch_up),
        .trip_reset_out(tr_pulse), .status_word_out(sw)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic send(input logic [15:0] w);
        mst_u.send_word(w);
        settle(2);
    endtask

    // k: 0 fault, 1 lockout fault, 2 power removed
    task automatic bump(input int k);
        @(posedge clk_in);
        #1;
        {pwr_off, lock, fault} = 3'b001 << k;
        @(posedge clk_in);
        #1;
        {pwr_off, lock, fault} = 3'b000;
        settle(2);
    endtask

    function automatic logic [15:0] exp_sw(input logic [11:0] s, input logic [4:0] d,
                                           input logic dp);
        logic [15:0] w;
        w = 16'h0000;
        w[0] = s[0];
        w[1] = s[0] & s[1];
        w[2] = ~s[1];
        w[7] = s[2];
        w[8] = s[3];
        w[9] = ~(s[10] | s[11]);
        w[10] = ~s[4];
        w[11] = s[5] | s[6];
        w[15:13] = s[9:7];
        if (dp) begin
            w[5] = d[0];
            w[15:12] = d[4:1];
        end
        return w;
    endfunction

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Pulse counter; sampled before the edge's own updates land
    always @(posedge clk_in) begin
        if (tr_pulse === 1'b1) begin
            pulses++;
        end
    end

    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        logic e;
        repeat (5) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        chk(sw, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            send(wt[i]);
            chk({13'h0, ramp2, relay, dout}, {13'h0, et[i]});
        end
        send(16'h047F);
        chk({6'h0, preset, run, coast_n, qstop_n, freeze_n, jog1, off_n}, 16'h03F7);
        send(16'h0500);
        chk({6'h0, preset, run, coast_n, qstop_n, freeze_n, jog1, off_n}, 16'h000F);
        st = 12'h400;
        send(16'h0E08);
        chk({13'h0, ramp2, relay, dout}, 16'h0000);
        st = 12'h000;
        $display("test native_decode done");
        send(16'h6408);
        chk({14'h0, setup_sel}, 16'h0000);
        setup_mode = 2'b01;
        for (int k = 0; k < 4; k++) begin
            send({1'b0, 2'(k), 13'h0408});
            chk({14'h0, setup_sel}, 16'(k));
        end
        $display("test setup_select done");
        for (int m = 0; m < 16; m++) begin
            rev_src = 2'(m);
            rev_dig = m[2];
            send({m[3], 15'h0408});
            case (rev_src)
                2'b00: e = m[2];
                2'b01: e = m[3];
                2'b10: e = m[2] | m[3];
                default: e = m[2] & m[3];
            endcase
            chk({15'h0, rev}, {15'h0, e});
        end
        $display("test reversing done");
        send(16'h0408);
        bump(0);
        chk(sw & 16'h0008, 16'h0008);
        send(16'h0488);
        settle(1);
        chk(16'(pulses), 16'h0001);
        chk(sw & 16'h0008, 16'h0000);
        bump(0);
        send(16'h0488);
        settle(1);
        chk(16'(pulses), 16'h0001);
        chk(sw & 16'h0008, 16'h0008);
        send(16'h0408);
        send(16'h0488);
        settle(1);
        chk(16'(pulses), 16'h0002);
        chk(sw & 16'h0008, 16'h0000);
        bump(1);
        chk(sw & 16'h0040, 16'h0040);
        send(16'h0408);
        send(16'h0488);
        settle(1);
        chk(sw & 16'h0040, 16'h0040);
        bump(2);
        chk(sw & 16'h0040, 16'h0000);
        send(16'h0408);
        send(16'h0488);
        $display("test trip_and_lock done");
        din = 5'h1F;
        for (int i = 0; i < 24; i++) begin
            st = (12'h001 << (i / 2)) | 12'(i % 2);
            settle(2);
            chk(sw, exp_sw(st, din, 1'b0));
        end
        $display("test native_status done");
        dip = 1'b1;
        st = 12'h001;
        for (int i = 0; i < 6; i++) begin
            din = 5'(6'h01 << i);
            settle(PER + 3);
            chk(sw, exp_sw(st, din, 1'b1));
        end
        $display("test direct_inputs done");
        dip = 1'b0;
        din = 5'h00;
        msg_profile = 1'b0;
        send(16'h0D05);
        chk({4'h0, off_n, jog1, jog2, slow, catch_up, ramp2, relay, dout, preset}, 16'h0B40);
        send(16'h1602);
        chk({4'h0, off_n, jog1, jog2, slow, catch_up, ramp2, relay, dout, preset}, 16'h04A0);
        $display("test bus_layout done");
        end_of_test();
    end
endmodule
`default_nettype wire
